// ### hw/ivp_top.sv
/*
  Interrupt vector placement: reset address, vector table relocation,
  timed change of the vector base, request priority and vector output.
  Assumes request lines are single-clock, already masked by their
  sources' enables, and that the core gives a global enable and an
  acknowledge pulse when it loads the vector; the control register
  write comes in as a strobe with data from the core's I/O decode.
*/
`timescale 1ns/10ps
`default_nettype none
`include "ivp_consts.svh"
module ivp_top #(
  parameter int                  NUM_SRC   = `IVP_NUM_SRC,
  parameter logic [`IVP_PC_W-1:0] BOOT_ADDR = `IVP_BOOT_ADDR
) (
  // clock and reset
  input  wire logic                 MCLK_IN,
  input  wire logic                 NRST_IN,
  // fuse and core status
  input  wire logic                 BOOT_RESET_FUSE_IN,
  input  wire logic                 GLOBAL_IRQ_EN_IN,
  input  wire logic                 INSTR_DONE_IN,
  input  wire logic                 VEC_ACK_IN,
  // control register write and read
  input  wire logic                 CTRL_WR_IN,
  input  wire logic [7:0]           CTRL_WDATA_IN,
  output logic      [7:0]           CTRL_RDATA_OUT,
  // peripheral requests
  input  wire logic [NUM_SRC-1:0]   IRQ_REQ_IN,
  // core program-counter load
  output logic                      RESET_LOAD_OUT,
  output logic                      VEC_LOAD_OUT,
  output logic [`IVP_PC_W-1:0]      VEC_ADDR_OUT,
  output logic [4:0]                VEC_SRC_OUT,
  output logic                      IRQ_BLOCKED_OUT
);
  // parameter checks at elaboration; source index port is 5 bits wide
  if (NUM_SRC < 1 || NUM_SRC > 31)
  begin : g_bad_num_src
    $error("ivp_top: NUM_SRC out of range");
  end
  if (BOOT_ADDR + NUM_SRC >= (1 << `IVP_PC_W))
  begin : g_bad_boot_addr
    $error("ivp_top: table too high");
  end

  localparam logic [2:0] CHG_LAST = 3'(`IVP_CHG_CYCLES - 1);

  // control state
  logic                  sel_q;
  logic                  ce_q;
  logic [2:0]            ce_cnt_q;
  ivp_pkg::ivp_chg_t     chg_st_q;
  logic                  rst_pend_q;
  logic                  vec_load_q;
  logic [`IVP_PC_W-1:0]  vec_addr_q;
  logic [4:0]            vec_src_q;
  logic                  blocked_q;
  logic [7:0]            rdata_q;

  // decode of the control write
  wire wr_ce    = CTRL_WR_IN && CTRL_WDATA_IN[`IVP_BIT_CE];
  wire wr_sel   = CTRL_WR_IN && ce_q && !CTRL_WDATA_IN[`IVP_BIT_CE];
  wire ce_end   = ce_q && ce_cnt_q == CHG_LAST;
  // fuse is static from power-up on, so no synchroniser delays the reset address
  wire fuse_prog = BOOT_RESET_FUSE_IN == `IVP_FUSE_PROG;

  // picker
  wire       any_req;
  wire [4:0] win_idx;
  ivp_prio #(
    .N  (NUM_SRC),
    .IW (5)
  ) ivp_prio_i (
    .req_in  (IRQ_REQ_IN),
    .any_out (any_req),
    .idx_out (win_idx)
  );

  // table base and addresses
  wire [`IVP_PC_W-1:0] vec_base  = sel_q ? BOOT_ADDR : `IVP_RESET_ADDR;
  wire [`IVP_PC_W-1:0] vec_addr  = vec_base + `IVP_FIRST_VEC
                                   + `IVP_PC_W'(win_idx);
  wire [`IVP_PC_W-1:0] rst_addr  = fuse_prog ? BOOT_ADDR : `IVP_RESET_ADDR;

  // blocking window covers change-enable and one instruction after select
  wire block_now = ce_q || wr_ce || chg_st_q != ivp_pkg::IVP_IDLE;
  wire take      = any_req && GLOBAL_IRQ_EN_IN && !block_now
                   && !vec_load_q && !rst_pend_q;

  // change sequence state
  ivp_pkg::ivp_chg_t chg_st_d;
  always_comb
  begin
    chg_st_d = chg_st_q;
    unique case (chg_st_q)
      ivp_pkg::IVP_IDLE:
        if (wr_ce) chg_st_d = ivp_pkg::IVP_OPEN;
      ivp_pkg::IVP_OPEN:
        if (wr_sel) chg_st_d = ivp_pkg::IVP_HOLD;
        else if (ce_end) chg_st_d = ivp_pkg::IVP_IDLE;
      // a fresh change-enable during the hold must reopen the window
      ivp_pkg::IVP_HOLD:
        if (INSTR_DONE_IN && !wr_sel)
          chg_st_d = (ce_q || wr_ce) ? ivp_pkg::IVP_OPEN : ivp_pkg::IVP_IDLE;
    endcase
  end

  always_ff @(posedge MCLK_IN)
  begin
    if (!NRST_IN)
    begin
      chg_st_q <= ivp_pkg::IVP_IDLE;
      ce_q     <= 1'b0;
      ce_cnt_q <= 3'h0;
      sel_q    <= 1'b0;
    end
    else
    begin
      chg_st_q <= chg_st_d;
      if (wr_sel)
        sel_q <= CTRL_WDATA_IN[`IVP_BIT_SEL];
      if (wr_ce && !ce_q)
      begin
        ce_q     <= 1'b1;
        ce_cnt_q <= 3'h0;
      end
      else if (wr_sel || ce_end)
        ce_q <= 1'b0;
      else if (ce_q)
        ce_cnt_q <= ce_cnt_q + 3'h1;
    end
  end

  // reset vector issued once after release
  always_ff @(posedge MCLK_IN)
  begin
    if (!NRST_IN)
      rst_pend_q <= 1'b1;
    else
      rst_pend_q <= 1'b0;
  end

  // vector load held until the core acknowledges
  always_ff @(posedge MCLK_IN)
  begin
    if (!NRST_IN)
    begin
      vec_load_q <= 1'b0;
      vec_addr_q <= `IVP_RESET_ADDR;
      vec_src_q  <= 5'h00;
    end
    else if (rst_pend_q)
    begin
      vec_addr_q <= rst_addr;
    end
    else if (take)
    begin
      vec_load_q <= 1'b1;
      vec_addr_q <= vec_addr;
      vec_src_q  <= win_idx;
    end
    else if (VEC_ACK_IN)
      vec_load_q <= 1'b0;
  end

  always_ff @(posedge MCLK_IN)
  begin
    if (!NRST_IN)
    begin
      blocked_q <= 1'b0;
      rdata_q   <= 8'h00;
    end
    else
    begin
      blocked_q <= block_now;
      rdata_q   <= {6'h00, sel_q, ce_q};
    end
  end

  // reset load pulse registered separately
  logic rst_load_q;
  always_ff @(posedge MCLK_IN)
  begin
    if (!NRST_IN)
      rst_load_q <= 1'b0;
    else
      rst_load_q <= rst_pend_q;
  end

  assign RESET_LOAD_OUT  = rst_load_q;
  assign VEC_LOAD_OUT    = vec_load_q;
  assign VEC_ADDR_OUT    = vec_addr_q;
  assign VEC_SRC_OUT     = vec_src_q;
  assign IRQ_BLOCKED_OUT = blocked_q;
  assign CTRL_RDATA_OUT  = rdata_q;

  // checks on the reset load
  AST_RST_ADDR: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
    rst_load_q |-> VEC_ADDR_OUT == (fuse_prog ? BOOT_ADDR : `IVP_RESET_ADDR))
    else $error("reset address wrong");
  AST_RST_ONCE: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
    rst_load_q |=> !rst_load_q)
    else $error("reset load longer than one cycle");
  AST_NO_LOAD_RST: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
    rst_pend_q |=> !$rose(VEC_LOAD_OUT))
    else $error("vector load during reset load");

  // checks on the vector load
  AST_VEC_ADDR: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
    take |=> VEC_ADDR_OUT == (($past(sel_q) ? BOOT_ADDR : `IVP_RESET_ADDR)
                              + `IVP_FIRST_VEC + `IVP_PC_W'($past(win_idx))))
    else $error("vector address wrong");
  AST_SRC_RANGE: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
    VEC_LOAD_OUT |-> VEC_SRC_OUT < NUM_SRC)
    else $error("vector source out of range");
  AST_LOAD_CAUSE: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
    $rose(VEC_LOAD_OUT) |-> ((($past(IRQ_REQ_IN) >> VEC_SRC_OUT) & (NUM_SRC)'(1)) != '0)
      && $past(GLOBAL_IRQ_EN_IN))
    else $error("vector load without request");
  AST_LOAD_STANDS: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
    (VEC_LOAD_OUT && !VEC_ACK_IN) |=> VEC_LOAD_OUT && $stable(VEC_ADDR_OUT)
      && $stable(VEC_SRC_OUT))
    else $error("vector load changed before acknowledge");
  AST_ACK_DROPS: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
    (VEC_LOAD_OUT && VEC_ACK_IN) |=> !VEC_LOAD_OUT)
    else $error("vector load held after acknowledge");
  AST_PRIO: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
    $rose(VEC_LOAD_OUT) |-> ($past(IRQ_REQ_IN) & ((NUM_SRC)'(1) << VEC_SRC_OUT)
      - (NUM_SRC)'(1)) == '0)
    else $error("lower vector pending");

  // checks on the timed change sequence
  AST_NO_TAKE_BLOCK: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
    (ce_q || chg_st_q == ivp_pkg::IVP_HOLD) |=> !$rose(VEC_LOAD_OUT))
    else $error("vector taken while blocked");
  AST_BLOCK_ON_CE: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
    wr_ce |=> IRQ_BLOCKED_OUT)
    else $error("change-enable write cycle not blocked");
  AST_HOLD_ENDS: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
    (chg_st_q == ivp_pkg::IVP_HOLD && INSTR_DONE_IN && !wr_sel && !ce_q && !wr_ce)
      |=> chg_st_q == ivp_pkg::IVP_IDLE)
    else $error("block not lifted after instruction");
  AST_CE_TIMEOUT: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
    ($rose(ce_q) && !CTRL_WR_IN) ##1 !CTRL_WR_IN [*3] |=> !ce_q)
    else $error("change enable did not expire");
  AST_SEL_CLEARS_CE: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
    wr_sel |=> !ce_q)
    else $error("change enable kept after select write");
  AST_SEL_NEEDS_CE: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
    $changed(sel_q) |-> $past(ce_q) && $past(CTRL_WR_IN))
    else $error("select changed without enable");
  AST_BARE_WRITE: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
    (CTRL_WR_IN && !ce_q && !CTRL_WDATA_IN[`IVP_BIT_CE]) |=> $stable(sel_q) && !ce_q)
    else $error("write without enable took effect");
  AST_RDATA_TRACKS: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
    1'b1 |=> CTRL_RDATA_OUT == {6'h00, $past(sel_q), $past(ce_q)})
    else $error("control read value wrong");
  AST_SEL_RESET: assert property (@(posedge MCLK_IN)
    !$past(NRST_IN) |-> !sel_q)
    else $error("select not cleared by reset");
endmodule : ivp_top
`default_nettype wire

// ### common/ivp_consts.svh
/*
  Constants for the interrupt vector placement block: vector offsets,
  boot reset address, control bit positions, change-window length.
  Assumes word addresses of program memory, 12 bits wide.
*/
`ifndef IVP_CONSTS_SVH
`define IVP_CONSTS_SVH

`define IVP_PC_W          12
`define IVP_NUM_SRC       18
`define IVP_RESET_ADDR    12'h000
`define IVP_BOOT_ADDR     12'hc00
`define IVP_FIRST_VEC     12'h001
`define IVP_FUSE_PROG     1'b0
`define IVP_CHG_WINDOW_NS 40
`define IVP_CLK_NS        10
`define IVP_CHG_CYCLES    ((`IVP_CHG_WINDOW_NS + `IVP_CLK_NS - 1) / `IVP_CLK_NS)
`define IVP_BIT_SEL       1
`define IVP_BIT_CE        0
`define IVP_SRC_EXT0      0
`define IVP_SRC_EXT1      1
`define IVP_SRC_T2CMP     2
`define IVP_SRC_T2OVF     3
`define IVP_SRC_T1CAP     4
`define IVP_SRC_T1CMPA    5
`define IVP_SRC_T1CMPB    6
`define IVP_SRC_T1OVF     7
`define IVP_SRC_T0OVF     8
`define IVP_SRC_SERIAL    9
`define IVP_SRC_RXDONE    10
`define IVP_SRC_TXEMPTY   11
`define IVP_SRC_TXDONE    12
`define IVP_SRC_ADC       13
`define IVP_SRC_NVM       14
`define IVP_SRC_COMP      15
`define IVP_SRC_TWOWIRE   16
`define IVP_SRC_SELFPROG  17

`endif

// ### common/ivp_pkg.sv
/*
  Types for the interrupt vector placement block.
  Assumes ivp_consts.svh is on the include path.
*/
`include "ivp_consts.svh"
package ivp_pkg;
  typedef logic [`IVP_PC_W-1:0] ivp_addr_t;
  typedef enum logic [1:0] {IVP_IDLE, IVP_OPEN, IVP_HOLD} ivp_chg_t;
endpackage : ivp_pkg

// ### hw/ivp_prio.sv
/*
  Fixed-priority picker: lowest set index wins.
  Assumes a purely combinational use by its parent.
*/
`timescale 1ns/10ps
`default_nettype none
module ivp_prio #(
  parameter int N  = 18,
  parameter int IW = 5
) (
  // requests
  input  wire logic [N-1:0]  req_in,
  // result
  output logic               any_out,
  output logic [IW-1:0]      idx_out
);
  initial
  begin
    if ((1 << IW) < N) $error("ivp_prio: IW too small");
  end

  always_comb
  begin
    any_out = 1'b0;
    idx_out = '0;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (req_in[i])
      begin
        any_out = 1'b1;
        idx_out = IW'(i);
      end
    end
  end
endmodule : ivp_prio
`default_nettype wire

// ### tb/ivp_core_model.sv
/*
  Core fetch model: acknowledges a vector load lag_in + 1 cycles after it rises.
  Assumes the block's clock and reset.
*/
`timescale 1ns/10ps
`default_nettype none
module ivp_core_model (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  // load handshake
  input  wire logic       load_in,
  input  wire logic [3:0] lag_in,
  output logic            ack_out
);
  logic [3:0] cnt_q;
  // ack is one cycle; the load drops on the edge that sees it
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in || !load_in || ack_out)
    begin
      cnt_q   <= 4'h0;
      ack_out <= 1'b0;
    end
    else if (cnt_q == lag_in)
      ack_out <= 1'b1;
    else
      cnt_q <= cnt_q + 4'h1;
  end
endmodule : ivp_core_model
`default_nettype wire

// ### tb/interrupt_vector_placement_test.sv
/*
  Self-checking bench for ivp_top with a core model.
  Assumes the constants header on the include path.
*/
`timescale 1ns/10ps
`default_nettype none
`include "ivp_consts.svh"
module interrupt_vector_placement_test;
  logic               clk, rst_n, fuse, gie, idone, ack, wr, rld, vload, blk;
  logic [7:0]         wdata, rdata;
  logic [17:0]        req;
  logic [4:0]         src;
  logic [3:0]         lag;
  ivp_pkg::ivp_addr_t vaddr;
  int                 fails, checked, cyc;

  ivp_top ivp_top_i (.MCLK_IN(clk), .NRST_IN(rst_n), .BOOT_RESET_FUSE_IN(fuse),
    .GLOBAL_IRQ_EN_IN(gie), .INSTR_DONE_IN(idone), .VEC_ACK_IN(ack), .CTRL_WR_IN(wr),
    .CTRL_WDATA_IN(wdata), .CTRL_RDATA_OUT(rdata), .IRQ_REQ_IN(req),
    .RESET_LOAD_OUT(rld), .VEC_LOAD_OUT(vload), .VEC_ADDR_OUT(vaddr),
    .VEC_SRC_OUT(src), .IRQ_BLOCKED_OUT(blk));
  ivp_core_model ivp_core_model_i (.clk_in(clk), .rst_n_in(rst_n), .load_in(vload),
    .lag_in(lag), .ack_out(ack));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic end_of_test();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test

  // run is well under 2000 cycles
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      fails++;
      end_of_test();
    end
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task automatic cmp_addr(input string nm, input ivp_pkg::ivp_addr_t e, input ivp_pkg::ivp_addr_t g);
    checked++;
    if (g !== e)
    begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp_addr

  task automatic cmp_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e)
    begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp_byte

  // waits for the load, checks it, then lets the core ack it
  task automatic take(input int i, input ivp_pkg::ivp_addr_t base);
    int n;
    n = 0;
    while (vload !== 1'b1 && n < 20)
    begin
      step(1);
      n++;
    end
    cmp_byte("vector load", 8'h01, {7'h0, vload});
    cmp_addr("vector address", base + 12'h001 + i[11:0], vaddr);
    cmp_byte("vector source", {3'h0, i[4:0]}, {3'h0, src});
    req = 18'h0;
    while (vload === 1'b1 && n < 40)
    begin
      step(1);
      n++;
    end
  endtask : take

  task automatic do_reset(input logic f);
    rst_n = 1'b0;
    fuse = f;
    step(3);
    rst_n = 1'b1;
    step(1);
    cmp_addr("reset address", f ? `IVP_RESET_ADDR : `IVP_BOOT_ADDR, vaddr);
    cmp_byte("control after reset", 8'h00, rdata);
    cmp_byte("reset load", 8'h01, {7'h0, rld});
    step(1);
    cmp_byte("reset load after pulse", 8'h00, {7'h0, rld});
  endtask : do_reset

  task automatic s_vectors(input ivp_pkg::ivp_addr_t base);
    for (int i = 0; i < 18; i++)
    begin
      req = 18'h1 << i;
      take(i, base);
    end
  endtask : s_vectors

  task automatic s_priority();
    req = 18'h20020;
    take(5, `IVP_RESET_ADDR);
  endtask : s_priority

  task automatic s_gie_off();
    gie = 1'b0;
    req = 18'h00001;
    step(5);
    cmp_byte("load with interrupts off", 8'h00, {7'h0, vload});
    gie = 1'b1;
    take(0, `IVP_RESET_ADDR);
  endtask : s_gie_off

  task automatic s_relocate();
    wr = 1'b1;
    wdata = 8'h01;
    step(1);
    cmp_byte("blocked in enable write", 8'h01, {7'h0, blk});
    wdata = 8'h02;
    req = 18'h00004;
    step(1);
    wr = 1'b0;
    step(3);
    cmp_byte("load before instruction end", 8'h00, {7'h0, vload});
    cmp_byte("blocked before instruction end", 8'h01, {7'h0, blk});
    cmp_byte("control after select", 8'h02, rdata);
    idone = 1'b1;
    step(1);
    idone = 1'b0;
    take(2, `IVP_BOOT_ADDR);
    cmp_byte("blocked after instruction end", 8'h00, {7'h0, blk});
  endtask : s_relocate

  task automatic s_expiry();
    wr = 1'b1;
    wdata = 8'h01;
    step(1);
    wr = 1'b0;
    req = 18'h00080;
    step(1);
    cmp_byte("control in window", 8'h03, rdata);
    step(2);
    cmp_byte("load in window", 8'h00, {7'h0, vload});
    cmp_byte("blocked in window", 8'h01, {7'h0, blk});
    take(7, `IVP_BOOT_ADDR);
    cmp_byte("control after expiry", 8'h02, rdata);
    wr = 1'b1;
    wdata = 8'h00;
    step(1);
    wr = 1'b0;
    step(2);
    cmp_byte("control after bare write", 8'h02, rdata);
    wr = 1'b1;
    wdata = 8'h01;
    step(1);
    wdata = 8'h00;
    step(1);
    wr = 1'b0;
    idone = 1'b1;
    step(1);
    idone = 1'b0;
    cmp_byte("control after clearing select", 8'h00, rdata);
  endtask : s_expiry

  initial
  begin
    rst_n = 1'b0;
    fuse = 1'b1;
    gie = 1'b1;
    idone = 1'b0;
    wr = 1'b0;
    wdata = 8'h00;
    req = 18'h0;
    lag = 4'h0;
    do_reset(1'b1);
    s_vectors(`IVP_RESET_ADDR);
    s_priority();
    s_gie_off();
    s_relocate();
    lag = 4'h3;
    s_vectors(`IVP_BOOT_ADDR);
    s_expiry();
    do_reset(1'b0);
    s_vectors(`IVP_RESET_ADDR);
    end_of_test();
  end
endmodule : interrupt_vector_placement_test
`default_nettype wire
